// >>> core/egd_pkg.sv
package egd_pkg;
  // Channel slots: five full-bandwidth, then coupling, then low frequency effects
  localparam int EGD_NCH = 7;
  localparam int EGD_NBIN = 256;
  localparam logic [2:0] EGD_CH_CPL = 3'h5;
  localparam logic [2:0] EGD_CH_LFE = 3'h6;

  // Register byte offsets
  localparam logic [3:0] EGD_OFS_CTRL = 4'h0;
  localparam logic [3:0] EGD_OFS_STATUS = 4'h4;
  localparam logic [3:0] EGD_OFS_EXP_ADDR = 4'h8;
  localparam logic [3:0] EGD_OFS_EXP_DATA = 4'hC;

  // Control field positions
  localparam int EGD_CTRL_CHAN_LSB = 0;
  localparam int EGD_CTRL_STRAT_LSB = 3;
  localparam int EGD_CTRL_COUPLED_BIT = 5;
  localparam int EGD_CTRL_BW_LSB = 6;
  localparam int EGD_CTRL_CPLBEG_LSB = 12;
  localparam int EGD_CTRL_CPLEND_LSB = 16;
  localparam int EGD_CTRL_BLOCK0_BIT = 20;
  localparam int EGD_CTRL_LFE_EN_BIT = 21;
  localparam int EGD_CTRL_START_BIT = 31;
  localparam int EGD_CTRL_W = 22;
  localparam logic [21:0] EGD_CTRL_RESET = 22'h000000;

  // Status bit positions
  localparam int EGD_ST_BUSY_BIT = 0;
  localparam int EGD_ST_DONE_BIT = 1;
  localparam int EGD_ST_REUSE_ERR_BIT = 2;
  localparam int EGD_ST_RANGE_ERR_BIT = 3;
  localparam int EGD_ST_CMD_ERR_BIT = 4;

  // Strategy codes
  localparam logic [1:0] EGD_STR_REUSE = 2'h0;
  localparam logic [1:0] EGD_STR_SINGLE = 2'h1;
  localparam logic [1:0] EGD_STR_PAIR = 2'h2;
  localparam logic [1:0] EGD_STR_QUAD = 2'h3;

  // Bin arithmetic
  localparam logic [8:0] EGD_BIN_BASE = 9'h025;
  localparam logic [8:0] EGD_BW_OFS = 9'h00C;
  localparam logic [8:0] EGD_BW_MUL = 9'h003;
  localparam logic [8:0] EGD_CPL_MUL = 9'h00C;
  localparam logic [8:0] EGD_CPLEND_OFS = 9'h003;
  localparam logic [8:0] EGD_LFE_END = 9'h007;
  localparam logic [6:0] EGD_LFE_GRPS = 7'h02;
  localparam logic [6:0] EGD_GRP_DIV1 = 7'h19;
  localparam logic [6:0] EGD_GRP_DIV2 = 7'h05;
  localparam logic [6:0] EGD_MAP_BIAS = 7'h02;
  localparam logic [6:0] EGD_EXP_MAX = 7'h18;

  typedef enum logic [1:0] {EGD_KIND_FBW, EGD_KIND_CPL, EGD_KIND_LFE} egd_kind_t;
endpackage

// >>> core/egd_decoder.sv
`timescale 1ns/100ps
// Contract
// - Two-bit strategy: reuse, single, pair, quad.
// - LFE one-bit strategy: reuse or single.
// - Block 0 must never signal exponent reuse.
// - Mapped value minus two gives delta.
// - Seven-bit word splits by 25 and 5.
// - Absolute exponent accumulates deltas from reference.
// - Pair/quad write each exponent 2/4 bins.
// - First fbw/LFE field is 4-bit absolute.
// - Coupling reference doubled, never an output.
// - Uncoupled end bin (bw+12)*3+37.
// - Coupled end equals coupling start; start zero.
// - Coupling start/end bins from begin/end codes.
// - LFE bins 0 to 7, two groups.
// - Channel group counts per strategy formula.
// - Coupling groups: bin span over 3/6/12.
// - Coupling element n+1 stored at n+start.
// - Exponents delivered as 5-bit per bin.
// - Valid exponents 0 to 24 inclusive.
module egd_decoder
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic field_valid,
  input wire logic [6:0] field_data,
  output logic field_ready,
  output logic exp_valid,
  output logic [2:0] exp_chan,
  output logic [7:0] exp_bin,
  output logic [4:0] exp_value
);
  import egd_pkg::*;

  typedef enum logic [1:0] {EGD_IDLE, EGD_ABS, EGD_GRP, EGD_EXP} egd_state_t;

  egd_state_t state_reg, state_next;
  logic [EGD_CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [10:0] eaddr_reg, eaddr_next;
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic reuse_err_reg, reuse_err_next;
  logic range_err_reg, range_err_next;
  logic cmd_err_reg, cmd_err_next;
  logic [2:0] chan_reg, chan_next;
  egd_kind_t kind_reg, kind_next;
  logic [2:0] gsize_reg, gsize_next;
  logic [6:0] ngrps_reg, ngrps_next;
  logic [6:0] gcnt_reg, gcnt_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [4:0] acc_reg, acc_next;
  logic [2:0] m_reg [3];
  logic [2:0] m_next [3];
  logic [1:0] idx_reg, idx_next;
  logic [2:0] rep_reg, rep_next;
  logic ready_reg, ready_next;
  logic ov_reg, ov_next;
  logic [2:0] oc_reg, oc_next;
  logic [7:0] ob_reg, ob_next;
  logic [4:0] oe_reg, oe_next;
  logic [4:0] mem [EGD_NCH][EGD_NBIN];

  logic bus_req, bus_done, wr_ctrl, wr_status, wr_eaddr;
  logic [31:0] bmask, ctrl_w;
  logic start_cmd, take;
  logic [1:0] strat;
  egd_kind_t kind_w;
  logic [8:0] cpl_start, cpl_end, end_bin, span;
  logic [6:0] word, rem25, sum;

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign field_ready = ready_reg;
  assign exp_valid = ov_reg;
  assign exp_chan = oc_reg;
  assign exp_bin = ob_reg;
  assign exp_value = oe_reg;

  always_comb
  begin
    bus_req = avs_read || avs_write;
    // Each access answers one cycle after it is seen; the write lands on the edge that ends the answer cycle
    bus_done = bus_req && !wait_reg;
    bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    ctrl_w = ({10'h000, ctrl_reg} & ~bmask) | (avs_writedata & bmask);
    wr_ctrl = bus_done && avs_write && avs_address[3:2] == EGD_OFS_CTRL[3:2];
    wr_status = bus_done && avs_write && avs_address[3:2] == EGD_OFS_STATUS[3:2];
    wr_eaddr = bus_done && avs_write && avs_address[3:2] == EGD_OFS_EXP_ADDR[3:2];
    start_cmd = wr_ctrl && ctrl_w[EGD_CTRL_START_BIT] && !busy_reg;
    take = field_valid && ready_reg;

    wait_next = !(bus_req && wait_reg);
    rdata_next = rdata_reg;
    if (bus_req && wait_reg)
    begin
      unique case (avs_address[3:2])
        EGD_OFS_CTRL[3:2]: rdata_next = {10'h000, ctrl_reg};
        EGD_OFS_STATUS[3:2]: rdata_next = {27'h0000000, cmd_err_reg, range_err_reg,
                                           reuse_err_reg, done_reg, busy_reg};
        EGD_OFS_EXP_ADDR[3:2]: rdata_next = {21'h000000, eaddr_reg};
        EGD_OFS_EXP_DATA[3:2]: rdata_next = (eaddr_reg[10:8] < EGD_CH_LFE + 3'h1) ?
          {27'h0000000, mem[eaddr_reg[10:8]][eaddr_reg[7:0]]} : 32'h00000000;
      endcase
    end

    // Parameters are frozen while a set decodes
    ctrl_next = (wr_ctrl && !busy_reg) ? ctrl_w[EGD_CTRL_W-1:0] : ctrl_reg;
    eaddr_next = wr_eaddr ? avs_writedata[10:0] : eaddr_reg;

    kind_w = (ctrl_w[2:0] == EGD_CH_CPL) ? EGD_KIND_CPL :
             (ctrl_w[2:0] == EGD_CH_LFE) ? EGD_KIND_LFE : EGD_KIND_FBW;
    strat = (kind_w == EGD_KIND_LFE) ? {1'b0, ctrl_w[EGD_CTRL_STRAT_LSB]} :
            ctrl_w[EGD_CTRL_STRAT_LSB +: 2];
    cpl_start = {5'h00, ctrl_w[EGD_CTRL_CPLBEG_LSB +: 4]} * EGD_CPL_MUL + EGD_BIN_BASE;
    cpl_end = ({5'h00, ctrl_w[EGD_CTRL_CPLEND_LSB +: 4]} + EGD_CPLEND_OFS) * EGD_CPL_MUL
              + EGD_BIN_BASE;
    // uncoupled end bin; coupled end bin
    end_bin = ctrl_w[EGD_CTRL_COUPLED_BIT] ? cpl_start :
              ({3'h0, ctrl_w[EGD_CTRL_BW_LSB +: 6]} + EGD_BW_OFS) * EGD_BW_MUL + EGD_BIN_BASE;
    span = cpl_end - cpl_start;

    word = field_data;
    rem25 = word % EGD_GRP_DIV1;

    state_next = state_reg;
    busy_next = busy_reg;
    // Flags are cleared by writing one; a same-cycle set below still wins
    done_next = done_reg && !(wr_status && avs_writedata[EGD_ST_DONE_BIT]);
    reuse_err_next = reuse_err_reg && !(wr_status && avs_writedata[EGD_ST_REUSE_ERR_BIT]);
    range_err_next = range_err_reg && !(wr_status && avs_writedata[EGD_ST_RANGE_ERR_BIT]);
    cmd_err_next = cmd_err_reg && !(wr_status && avs_writedata[EGD_ST_CMD_ERR_BIT]);
    chan_next = chan_reg;
    kind_next = kind_reg;
    gsize_next = gsize_reg;
    ngrps_next = ngrps_reg;
    gcnt_next = gcnt_reg;
    ptr_next = ptr_reg;
    acc_next = acc_reg;
    m_next = m_reg;
    idx_next = idx_reg;
    rep_next = rep_reg;
    ov_next = 1'b0;
    oc_next = oc_reg;
    ob_next = ob_reg;
    oe_next = oe_reg;
    sum = {2'h0, acc_reg} + {4'h0, m_reg[idx_reg]} - EGD_MAP_BIAS;

    unique case (state_reg)
      EGD_IDLE:
      begin
        if (start_cmd)
        begin
          chan_next = ctrl_w[2:0];
          kind_next = kind_w;
          gcnt_next = 7'h00;
          // element 1 of a coupling set lands on its start bin
          ptr_next = cpl_start[7:0];
          // strategy decides group size and count
          gsize_next = (strat == EGD_STR_QUAD) ? 3'h4 :
                       (strat == EGD_STR_PAIR) ? 3'h2 : {2'h0, strat[0]};
          // channel group counts; coupling group counts
          unique case (strat)
            EGD_STR_PAIR: ngrps_next = (kind_w == EGD_KIND_CPL) ? 7'(span / 9'h006) :
                                       7'((end_bin + 9'h002) / 9'h006);
            EGD_STR_QUAD: ngrps_next = (kind_w == EGD_KIND_CPL) ? 7'(span / 9'h00C) :
                                       7'((end_bin + 9'h008) / 9'h00C);
            // fixed LFE group count over bins 0..7
            default: ngrps_next = (kind_w == EGD_KIND_LFE) ? EGD_LFE_GRPS :
                                  (kind_w == EGD_KIND_CPL) ? 7'(span / 9'h003) :
                                  7'((end_bin - 9'h001) / 9'h003);
          endcase
          if (ctrl_w[2:0] > EGD_CH_LFE ||
              (kind_w == EGD_KIND_LFE && !ctrl_w[EGD_CTRL_LFE_EN_BIT]))
          begin
            cmd_err_next = 1'b1;
            done_next = 1'b1;
          end
          // reuse in block 0 is refused and flagged
          else if (strat == EGD_STR_REUSE && ctrl_w[EGD_CTRL_BLOCK0_BIT])
          begin
            reuse_err_next = 1'b1;
            done_next = 1'b1;
          end
          // reuse keeps the stored array and reads nothing
          else if (strat == EGD_STR_REUSE)
          begin
            done_next = 1'b1;
          end
          else
          begin
            busy_next = 1'b1;
            done_next = 1'b0;
            state_next = EGD_ABS;
          end
        end
      end
      EGD_ABS:
      begin
        if (take)
        begin
          // coupling reference doubled, held only as accumulator start
          if (kind_reg == EGD_KIND_CPL)
          begin
            acc_next = {field_data[3:0], 1'b0};
          end
          // four-bit absolute exponent for bin 0, MSB zero
          else
          begin
            acc_next = {1'b0, field_data[3:0]};
            ptr_next = 8'h01;
            ov_next = 1'b1;
            oc_next = chan_reg;
            ob_next = 8'h00;
            oe_next = {1'b0, field_data[3:0]};
          end
          state_next = EGD_GRP;
        end
      end
      EGD_GRP:
      begin
        if (gcnt_reg == ngrps_reg)
        begin
          state_next = EGD_IDLE;
          busy_next = 1'b0;
          done_next = 1'b1;
        end
        else if (take)
        begin
          // split the grouped word into three mapped values
          m_next[0] = 3'(word / EGD_GRP_DIV1);
          m_next[1] = 3'(rem25 / EGD_GRP_DIV2);
          m_next[2] = 3'(rem25 % EGD_GRP_DIV2);
          gcnt_next = gcnt_reg + 7'h01;
          idx_next = 2'h0;
          rep_next = 3'h0;
          state_next = EGD_EXP;
        end
      end
      EGD_EXP:
      begin
        // subtract bias; accumulate once per mapped value
        if (rep_reg == 3'h0)
        begin
          acc_next = sum[4:0];
          // flag results outside 0..24, negatives wrap high
          if (sum > EGD_EXP_MAX)
          begin
            range_err_next = 1'b1;
          end
        end
        // repeat each exponent over its pair or quad; 5-bit output
        ov_next = 1'b1;
        oc_next = chan_reg;
        ob_next = ptr_reg;
        oe_next = (rep_reg == 3'h0) ? sum[4:0] : acc_reg;
        ptr_next = ptr_reg + 8'h01;
        if (rep_reg + 3'h1 == gsize_reg)
        begin
          rep_next = 3'h0;
          idx_next = idx_reg + 2'h1;
          if (idx_reg == 2'h2)
          begin
            state_next = EGD_GRP;
          end
        end
        else
        begin
          rep_next = rep_reg + 3'h1;
        end
      end
    endcase

    ready_next = (state_next == EGD_ABS) ||
                 (state_next == EGD_GRP && gcnt_next != ngrps_next);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= EGD_IDLE;
      ctrl_reg <= EGD_CTRL_RESET;
      eaddr_reg <= 11'h000;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      reuse_err_reg <= 1'b0;
      range_err_reg <= 1'b0;
      cmd_err_reg <= 1'b0;
      chan_reg <= 3'h0;
      kind_reg <= EGD_KIND_FBW;
      gsize_reg <= 3'h1;
      ngrps_reg <= 7'h00;
      gcnt_reg <= 7'h00;
      ptr_reg <= 8'h00;
      acc_reg <= 5'h00;
      m_reg <= '{3'h0, 3'h0, 3'h0};
      idx_reg <= 2'h0;
      rep_reg <= 3'h0;
      ready_reg <= 1'b0;
      ov_reg <= 1'b0;
      oc_reg <= 3'h0;
      ob_reg <= 8'h00;
      oe_reg <= 5'h00;
    end
    else
    begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      eaddr_reg <= eaddr_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      reuse_err_reg <= reuse_err_next;
      range_err_reg <= range_err_next;
      cmd_err_reg <= cmd_err_next;
      chan_reg <= chan_next;
      kind_reg <= kind_next;
      gsize_reg <= gsize_next;
      ngrps_reg <= ngrps_next;
      gcnt_reg <= gcnt_next;
      ptr_reg <= ptr_next;
      acc_reg <= acc_next;
      m_reg <= m_next;
      idx_reg <= idx_next;
      rep_reg <= rep_next;
      ready_reg <= ready_next;
      ov_reg <= ov_next;
      oc_reg <= oc_next;
      ob_reg <= ob_next;
      oe_reg <= oe_next;
    end
  end

  // per-channel array holds its last set until overwritten
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int c = 0; c < EGD_NCH; c++)
      begin
        for (int b = 0; b < EGD_NBIN; b++)
        begin
          mem[c][b] <= 5'h00;
        end
      end
    end
    else if (ov_next)
    begin
      mem[oc_next][ob_next] <= oe_next;
    end
  end
endmodule

// >>> tb/egd_decoder_asserts.sv
`timescale 1ns/100ps
module egd_decoder_asserts
  import egd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic field_valid,
  input wire logic field_ready,
  input wire logic exp_valid,
  input wire logic [2:0] exp_chan,
  input wire logic [7:0] exp_bin,
  input wire logic [4:0] exp_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus access not answered in one cycle");
  // The absolute field leaves ready up for the first word behind it
  ready_drop_a: assert property (field_valid && field_ready |-> ##[1:3] !field_ready)
    else $error("field ready held after a take");
  bin_step_a: assert property (
    exp_valid ##1 exp_valid |-> exp_bin == $past(exp_bin) + 8'h01 && $stable(exp_chan))
    else $error("output bins not consecutive");
  delta_step_a: assert property (
    exp_valid ##1 exp_valid |->
      exp_value <= $past(exp_value) + 5'h02 && $past(exp_value) <= exp_value + 5'h02)
    else $error("exponent step larger than two");
  abs_first_a: assert property (exp_valid && exp_bin == 8'h00 |-> exp_value <= 5'h0F)
    else $error("first exponent above fifteen");
  cpl_bins_a: assert property (
    exp_valid && exp_chan == EGD_CH_CPL |-> exp_bin >= 8'h25)
    else $error("coupling exponent below its start bin");
  lfe_bins_a: assert property (
    exp_valid && exp_chan == EGD_CH_LFE |-> exp_bin < 8'h07)
    else $error("effects exponent beyond its end bin");
  exp_range_a: assert property (exp_valid |-> exp_value <= 5'h18)
    else $error("exponent above twenty four");
endmodule

bind egd_decoder egd_decoder_asserts i_chk (.clk(clk), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .field_valid(field_valid),
  .field_ready(field_ready), .exp_valid(exp_valid), .exp_chan(exp_chan),
  .exp_bin(exp_bin), .exp_value(exp_value));

// >>> tb/egd_field_src.sv
`timescale 1ns/100ps
module egd_field_src (
  input wire logic clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic field_ready,
  output logic field_valid,
  output logic [6:0] field_data
);
  logic [6:0] q [$];
  logic took;
  logic nv;

  // A field stands until taken; an idle line shows the inverse of its last value
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      field_valid <= 1'b0;
      field_data <= 7'h2A;
    end
    else
    begin
      took = field_valid && field_ready;
      if (took)
        void'(q.pop_front());
      // Slow mode leaves a gap after each take
      nv = q.size() > 0 && !(slow && took);
      field_valid <= nv;
      field_data <= nv ? q[0] : ~field_data;
    end
  end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import egd_pkg::*;
  logic clk, resetn, avs_read, avs_write, avs_waitrequest, slow;
  logic field_valid, field_ready, exp_valid;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, st, lc;
  logic [6:0] field_data;
  logic [2:0] exp_chan, chan;
  logic [7:0] exp_bin;
  logic [4:0] exp_value;
  logic [4:0] obs [256];
  logic [4:0] ex [256];
  // The word cycle nets a zero delta, so exponents stay in range
  logic [6:0] wt [4] = '{7'h7C, 7'h00, 7'h57, 7'h25};
  int errors, comparisons, npulse, lb;

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  egd_decoder i_dut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .field_valid(field_valid), .field_data(field_data), .field_ready(field_ready),
    .exp_valid(exp_valid), .exp_chan(exp_chan), .exp_bin(exp_bin), .exp_value(exp_value));

  egd_field_src i_src (.clk(clk), .resetn(resetn), .slow(slow), .field_ready(field_ready),
    .field_valid(field_valid), .field_data(field_data));

  task results;
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want)
    begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task hang;
    errors++;
    results;
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      hang;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  function automatic logic [31:0] cw(input int ch, s, cp, bw, cb, ce, b0, le);
    return ch | s << EGD_CTRL_STRAT_LSB | cp << EGD_CTRL_COUPLED_BIT | bw << EGD_CTRL_BW_LSB
      | cb << EGD_CTRL_CPLBEG_LSB | ce << EGD_CTRL_CPLEND_LSB | b0 << EGD_CTRL_BLOCK0_BIT
      | le << EGD_CTRL_LFE_EN_BIT;
  endfunction

  // Feeds one exponent set, starts a decode and compares every written bin
  task automatic run(input logic [31:0] c, input logic [4:0] a, input int nw, gs, f, cp);
    int b, n;
    logic [4:0] p;
    logic [6:0] w;
    npulse = 0;
    chan = c[2:0];
    lc = c & 32'h003F_FFFF;
    for (int i = 0; i < 256; i++)
      obs[i] = 'x;
    if (gs != 0)
      i_src.q.push_back({3'h0, a[3:0]});
    for (int g = 0; g < nw; g++)
      i_src.q.push_back(wt[g % 4]);
    bus(1'b1, EGD_OFS_CTRL, c | 32'h8000_0000);
    n = 0;
    do
    begin
      bus(1'b0, EGD_OFS_STATUS, 32'h0);
      n++;
    end
    while (rd[EGD_ST_DONE_BIT] !== 1'b1 && n < 300);
    if (n >= 300)
      hang;
    st = rd;
    p = cp ? {a[3:0], 1'b0} : a;
    b = f;
    if (!cp && gs != 0)
    begin
      ex[0] = p;
      b = 1;
    end
    for (int g = 0; g < nw; g++)
    begin
      w = wt[g % 4];
      for (int k = 0; k < 3; k++)
      begin
        p = p + (k == 0 ? w / 25 : k == 1 ? w % 25 / 5 : w % 5) - 2;
        for (int j = 0; j < gs; j++)
        begin
          ex[b] = p;
          b++;
        end
      end
    end
    for (int i = f; i < b; i++)
      chk(obs[i], ex[i]);
    chk(npulse, b - f);
    if (b > f)
      lb = b - 1;
    bus(1'b1, EGD_OFS_EXP_ADDR, {21'h0, chan, lb[7:0]});
    bus(1'b0, EGD_OFS_EXP_DATA, 32'h0);
    chk(rd[4:0], ex[lb]);
    bus(1'b1, EGD_OFS_STATUS, 32'h1E);
  endtask

  always @(posedge clk)
    if (exp_valid === 1'b1)
    begin
      obs[exp_bin] = exp_value;
      npulse++;
      chk(exp_chan, chan);
    end

  initial
  begin
    resetn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    slow = 1'b0;
    errors = 0;
    comparisons = 0;
    lb = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, EGD_OFS_CTRL, 32'h0);
    chk(rd, {10'h0, EGD_CTRL_RESET});
    bus(1'b0, EGD_OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    // Coupled channel ends at bin 37 for every strategy; pair mode stalls the source
    for (int s = 1; s < 4; s++)
    begin
      slow <= (s == 2);
      run(cw(0, s, 1, 0, 0, 0, s == 1, 0), 5'h0A, (33 + (3 << (s - 1))) / (3 << (s - 1)),
        1 << (s - 1), 0, 0);
    end
    slow <= 1'b0;
    run(cw(0, 0, 1, 0, 0, 0, 0, 0), 5'h00, 0, 0, 0, 0);
    run(cw(0, 0, 1, 0, 0, 0, 1, 0), 5'h00, 0, 0, 0, 0);
    chk(st[EGD_ST_REUSE_ERR_BIT], 1'b1);
    run(cw(1, 1, 0, 1, 0, 0, 1, 0), 5'h0A, (13 * 3 + 36) / 3, 1, 0, 0);
    // Coupling spans bins 49 to 97
    for (int s = 1; s < 4; s++)
      run(cw(5, s, 0, 0, 1, 2, 0, 0), 5'h05, 48 / (3 << (s - 1)), 1 << (s - 1), 49, 1);
    run(cw(6, 1, 0, 0, 0, 0, 0, 1), 5'h0F, 2, 1, 0, 0);
    run(cw(6, 0, 0, 0, 0, 0, 0, 1), 5'h00, 0, 0, 0, 0);
    run(cw(6, 1, 0, 0, 0, 0, 0, 0), 5'h00, 0, 0, 0, 0);
    chk(st[EGD_ST_CMD_ERR_BIT], 1'b1);
    bus(1'b0, 4'h3, 32'h0);
    chk(rd, lc);
    bus(1'b0, EGD_OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    // A second reset clears the control word and every stored exponent
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b1, EGD_OFS_EXP_ADDR, {21'h0, 3'h5, 8'h60});
    bus(1'b0, EGD_OFS_EXP_DATA, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, EGD_OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    results;
  end
endmodule
